// ### rtl/ftdr_regs.svh
// Register indices, field positions, reset values and timing counts of the tape and rate block.
`ifndef FTDR_REGS_SVH
`define FTDR_REGS_SVH

// Register indices; the bus byte address is four times the index.
`define FTDR_ADDR_W      14
`define FTDR_DOR_IDX     12'h3f2
`define FTDR_TDR_IDX     12'h3f3
`define FTDR_DSR_IDX     12'h3f4
`define FTDR_DATA_IDX    12'h3f5
`define FTDR_CCR_IDX     12'h3f7
`define FTDR_RT_BASE     12'h400
`define FTDR_RT_SHADOW   12'h01f
`define FTDR_SHADOW_IDX  (`FTDR_RT_BASE + `FTDR_RT_SHADOW)
`define FTDR_STAT_IDX    12'h4f0
`define FTDR_CFGF2_IDX   12'h4f2

// Reset values.
`define FTDR_DOR_RST     8'h00
`define FTDR_DSR_RST     8'h02
`define FTDR_CFGF2_RST   8'h00
`define FTDR_TDR_RST     2'h0

// Field positions in a written byte.
`define FTDR_DSR_LOWPWR  6
`define FTDR_DSR_SWRST   7

// Bus responses.
`define FTDR_RESP_OKAY   2'h0
`define FTDR_RESP_SLVERR 2'h2

// Soft reset pulse length from the self-clearing bit.
`define FTDR_CLK_MHZ     200
`define FTDR_SRST_MIN_NS 100
`define FTDR_SRST_CYC    ((`FTDR_SRST_MIN_NS * `FTDR_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/ftdr_pkg.sv
// Types shared by the tape and rate register block.
package ftdr_pkg;

  typedef struct packed {
    logic       sw_reset;
    logic       low_power;
    logic       undef5;
    logic [2:0] precomp;
    logic [1:0] rate;
  } ftdr_dsr_t;

  typedef struct packed {
    logic [1:0] mot_hi;
    logic       mot1;
    logic       mot0;
    logic       dma_en;
    logic       ctrl_reset_n;
    logic [1:0] drive;
  } ftdr_dor_t;

  typedef struct packed {
    logic drive_sel0_n;
    logic drive_sel1_n;
    logic motor_on0_n;
    logic motor_on1_n;
  } ftdr_pins_t;

endpackage

// ### rtl/ftdr_top.sv
// Tape assignment, drive decode and data-rate select registers behind an AXI4-Lite slave.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`include "ftdr_regs.svh"

module ftdr_top (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [`FTDR_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`FTDR_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     swap_decode,
  input  wire logic                     enhanced_mode2,
  input  wire logic [1:0]               boot_drive,
  output logic                          drive_sel0_n,
  output logic                          drive_sel1_n,
  output logic                          motor_on0_n,
  output logic                          motor_on1_n,
  output logic [1:0]                    rate_code,
  output logic [2:0]                    precomp_code,
  output logic                          low_power,
  output logic                          fdc_reset,
  output logic [1:0]                    tape_drive,
  output logic                          tape_active
);

  localparam logic [4:0] SRST_CYC = 5'(`FTDR_SRST_CYC);

  logic                     aw_hold_q;
  logic [11:0]              aw_idx_q;
  logic                     w_hold_q;
  logic [7:0]               w_data_q;
  logic                     w_lane0_q;
  logic                     bvalid_q;
  logic [1:0]               bresp_q;
  logic                     rvalid_q;
  logic [31:0]              rdata_q;
  logic [1:0]               rresp_q;
  logic                     wr_fire;
  logic                     wr_en;
  logic                     ar_take;
  logic [11:0]              ar_idx;
  logic                     wr_map;
  ftdr_pkg::ftdr_dor_t      dor_q;
  ftdr_pkg::ftdr_dsr_t      dsr_q;
  logic [1:0]               tdr_q;
  logic [7:0]               cfg_f2_q;
  logic [1:0]               rate_q;
  logic [4:0]               srst_cnt_q;
  logic                     low_power_q;
  logic                     fdc_reset_q;
  logic                     fdc_reset_d;
  logic                     tape_active_q;
  logic                     dsr_wr;
  logic                     ccr_wr;
  logic                     lp_set;
  logic                     wake;
  logic [1:0]               type_id;
  logic [7:0]               tdr_view;
  ftdr_pkg::ftdr_pins_t     pins_q;
  ftdr_pkg::ftdr_pins_t     pins_d;
  logic [31:0]              rd_data;
  logic [1:0]               rd_resp;

  // Write address and data are taken in either order; the response waits for both.
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign wr_fire       = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_en         = wr_fire && w_lane0_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_comb begin
    wr_map = (aw_idx_q == `FTDR_DOR_IDX) || (aw_idx_q == `FTDR_TDR_IDX) ||
             (aw_idx_q == `FTDR_DSR_IDX) || (aw_idx_q == `FTDR_DATA_IDX) ||
             (aw_idx_q == `FTDR_CCR_IDX) || (aw_idx_q == `FTDR_SHADOW_IDX) ||
             (aw_idx_q == `FTDR_STAT_IDX) || (aw_idx_q == `FTDR_CFGF2_IDX);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      aw_idx_q  <= 12'h000;
      w_hold_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `FTDR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[`FTDR_ADDR_W-1:2];
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q  <= 1'b1;
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? `FTDR_RESP_OKAY : `FTDR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign dsr_wr = wr_en && (aw_idx_q == `FTDR_DSR_IDX);
  assign ccr_wr = wr_en && (aw_idx_q == `FTDR_CCR_IDX);
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_idx  = s_axi_araddr[`FTDR_ADDR_W-1:2];
  assign lp_set  = dsr_wr && w_data_q[`FTDR_DSR_LOWPWR];
  // A read of the rate-select or data register index, or a write to the data register index, wakes the controller.
  assign wake    = (ar_take && (ar_idx == `FTDR_DSR_IDX || ar_idx == `FTDR_DATA_IDX)) ||
                   (wr_fire && aw_idx_q == `FTDR_DATA_IDX);

  // Output register and drive-type table; only the hardware reset clears them.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dor_q    <= `FTDR_DOR_RST;
      cfg_f2_q <= `FTDR_CFGF2_RST;
    end else begin
      if (wr_en && aw_idx_q == `FTDR_DOR_IDX) begin
        dor_q <= w_data_q;
      end
      if (wr_en && aw_idx_q == `FTDR_CFGF2_IDX) begin
        cfg_f2_q <= w_data_q;
      end
    end
  end

  // Tape assignment is untouched by the controller soft reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdr_q <= `FTDR_TDR_RST;
    end else if (wr_en && aw_idx_q == `FTDR_TDR_IDX) begin
      tdr_q <= w_data_q[1:0];
    end
  end

  // The rate byte and its shadow copy; soft reset leaves them alone except the shadow's sw_reset bit, cleared at the end of the pulse.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dsr_q <= `FTDR_DSR_RST;
    end else if (dsr_wr) begin
      dsr_q <= w_data_q;
    end else if (srst_cnt_q == 5'd1) begin
      dsr_q.sw_reset <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_q <= 2'(`FTDR_DSR_RST);
    end else if (dsr_wr || ccr_wr) begin
      rate_q <= w_data_q[1:0];
    end
  end

  // Self-clearing reset stretched to the least reset time.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      srst_cnt_q <= 5'd0;
    end else if (dsr_wr && w_data_q[`FTDR_DSR_SWRST]) begin
      srst_cnt_q <= SRST_CYC;
    end else if (srst_cnt_q != 5'd0) begin
      srst_cnt_q <= srst_cnt_q - 5'd1;
    end
  end

  assign fdc_reset_d = !dor_q.ctrl_reset_n || (srst_cnt_q != 5'd0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fdc_reset_q <= 1'b1;
    end else begin
      fdc_reset_q <= fdc_reset_d;
    end
  end

  // Entering low power wins over a wake in the same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_power_q <= 1'b0;
    end else if (lp_set) begin
      low_power_q <= 1'b1;
    end else if (wake || fdc_reset_q) begin
      low_power_q <= 1'b0;
    end
  end

  // Drive decode; code 10 and 11 select nothing in a two-drive system.
  always_comb begin
    pins_d = '{drive_sel0_n: 1'b1, drive_sel1_n: 1'b1,
               motor_on0_n: !dor_q.mot0, motor_on1_n: !dor_q.mot1};
    if (dor_q.drive == 2'b00 && dor_q.mot0) begin
      pins_d.drive_sel0_n = 1'b0;
    end
    if (dor_q.drive == 2'b01 && dor_q.mot1) begin
      pins_d.drive_sel1_n = 1'b0;
    end
    if (swap_decode) begin
      pins_d = '{drive_sel0_n: pins_d.drive_sel1_n, drive_sel1_n: pins_d.drive_sel0_n,
                 motor_on0_n: pins_d.motor_on1_n, motor_on1_n: pins_d.motor_on0_n};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_q        <= '{default: 1'b1};
      tape_active_q <= 1'b0;
    end else begin
      pins_q        <= pins_d;
      tape_active_q <= (tdr_q != 2'b00) && (dor_q.drive == tdr_q);
    end
  end

  // Read path; the rate byte itself is write only and its index reads zero.
  assign type_id  = cfg_f2_q[{dor_q.drive, 1'b0} +: 2];
  assign tdr_view = enhanced_mode2 ? {2'b00, type_id, boot_drive, tdr_q}
                                   : {6'h00, tdr_q};

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_resp = `FTDR_RESP_OKAY;
    unique case (ar_idx)
      `FTDR_DOR_IDX:    rd_data = {24'h00_0000, dor_q};
      `FTDR_TDR_IDX:    rd_data = {24'h00_0000, tdr_view};
      `FTDR_DSR_IDX:    rd_data = 32'h0000_0000;
      `FTDR_DATA_IDX:   rd_data = 32'h0000_0000;
      `FTDR_CCR_IDX:    rd_data = 32'h0000_0000;
      `FTDR_SHADOW_IDX: rd_data = {24'h00_0000, dsr_q};
      `FTDR_STAT_IDX:   rd_data = {26'h000_0000, tape_active_q, low_power_q, fdc_reset_q,
                                   1'b0, rate_q};
      `FTDR_CFGF2_IDX:  rd_data = {24'h00_0000, cfg_f2_q};
      default:          rd_resp = `FTDR_RESP_SLVERR;
    endcase
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `FTDR_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_data;
      rresp_q  <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign drive_sel0_n = pins_q.drive_sel0_n;
  assign drive_sel1_n = pins_q.drive_sel1_n;
  assign motor_on0_n  = pins_q.motor_on0_n;
  assign motor_on1_n  = pins_q.motor_on1_n;
  assign rate_code    = rate_q;
  assign precomp_code = dsr_q.precomp;
  assign low_power    = low_power_q;
  assign fdc_reset    = fdc_reset_q;
  assign tape_drive   = tdr_q;
  assign tape_active  = tape_active_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // The tape flag is registered, so it reflects the assignment and drive of the cycle before.
  a_tdr_write: assert property ((wr_en && aw_idx_q == `FTDR_TDR_IDX) |=>
    tape_drive == $past(w_data_q[1:0])) else $error("tape select not stored");
  a_tape_boot: assert property (tape_active |-> $past(tape_drive) != 2'b00 &&
    $past(dor_q.drive) != 2'b00) else $error("drive 0 flagged as tape");
  a_sel_normal: assert property ((!swap_decode && dor_q.drive == 2'b00 && dor_q.mot0)
    |=> (!drive_sel0_n && drive_sel1_n)) else $error("normal select 0 wrong");
  a_sel_swap: assert property ((swap_decode && dor_q.drive == 2'b01 && dor_q.mot1)
    |=> (!drive_sel0_n && drive_sel1_n)) else $error("swapped select wrong");
  a_motor_map: assert property (!swap_decode |=>
    (motor_on0_n == !$past(dor_q.mot0) && motor_on1_n == !$past(dor_q.mot1)))
    else $error("motor output wrong");
  a_rate_latest: assert property ((ccr_wr || dsr_wr) |=>
    rate_code == $past(w_data_q[1:0])) else $error("rate not latest write");
  a_rate_hold: assert property ((fdc_reset && !ccr_wr && !dsr_wr) |=>
    $stable(rate_code)) else $error("rate moved without write");
  a_srst_len: assert property ((dsr_wr && w_data_q[`FTDR_DSR_SWRST]) |=> ##1
    fdc_reset[*8]) else $error("soft reset pulse too short");
  a_srst_clear: assert property ((srst_cnt_q == 5'd1 && dor_q.ctrl_reset_n && !dsr_wr)
    |=> ##1 !fdc_reset) else $error("soft reset did not clear");
  a_lp_wake: assert property ((low_power && wake && !lp_set) |=> !low_power)
    else $error("low power not left on access");
  a_lp_set: assert property (lp_set |=> low_power) else $error("low power not entered");
  a_bresp_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=>
    (s_axi_bvalid && $stable(s_axi_bresp))) else $error("write response dropped");

  c_soft_reset: cover property (dsr_wr && w_data_q[`FTDR_DSR_SWRST] ##[1:30] !fdc_reset);
  c_lp_wake: cover property (low_power ##[1:20] !low_power);
  c_swap_sel: cover property (swap_decode && !drive_sel1_n);
  c_mode2_read: cover property (ar_take && enhanced_mode2 && ar_idx == `FTDR_TDR_IDX);

endmodule

// ### verification/ftdr_drive_model.sv
// Behavioural pair of floppy drives watching the select and motor lines.
module ftdr_drive_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       drive_sel0_n,
  input  wire logic       drive_sel1_n,
  input  wire logic       motor_on0_n,
  input  wire logic       motor_on1_n,
  output logic [1:0]      spinning,
  output logic            both_selected
);
  timeunit 1ns;
  timeprecision 1ps;

  assign spinning = {!motor_on1_n, !motor_on0_n};

  // Two drives answering at once would fight on the shared read line.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      both_selected <= 1'b0;
    end else if (!drive_sel0_n && !drive_sel1_n) begin
      both_selected <= 1'b1;
    end
  end
endmodule

// ### verification/tb.sv
// Self-checking bench for the tape and rate register block.
`include "ftdr_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, swap_decode, enhanced_mode2, low_power, fdc_reset, tape_active;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, boot_drive, rate_code, tape_drive, rsp, spinning;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        drive_sel0_n, drive_sel1_n, motor_on0_n, motor_on1_n, both_selected;
  logic [2:0]  precomp_code;
  logic [7:0]  v, f2, d;
  int          bad_count, compares, n;

  ftdr_top i_ftdr_top (.*);
  ftdr_drive_model i_ftdr_drive_model (.*);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] dat);
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_reg(input logic [11:0] idx, output logic [31:0] dat);
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    dat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(negedge clk);
  endtask

  // Expected {select0, select1, motor0, motor1} levels, all active low.
  function automatic logic [3:0] pins(input logic [7:0] digital_output_reg, input logic sw);
    logic s0, s1;
    s0 = (digital_output_reg[1:0] == 2'h0) && digital_output_reg[4];
    s1 = (digital_output_reg[1:0] == 2'h1) && digital_output_reg[5];
    if (sw) return {!s1, !s0, !digital_output_reg[5], !digital_output_reg[4]};
    return {!s0, !s1, !digital_output_reg[4], !digital_output_reg[5]};
  endfunction

  task automatic hw_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({drive_sel0_n, drive_sel1_n, motor_on0_n, motor_on1_n}, 4'hf);
    chk(rate_code, 2'h2);
    chk(precomp_code, 3'h0);
    chk(tape_drive, 2'h0);
    chk(fdc_reset, 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #100us;
    bad_count++;
    end_of_test();
  end

  initial begin
    {rst, swap_decode, enhanced_mode2, boot_drive} = 5'h10;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h1;
    void'($urandom(39093));
    hw_reset();
    wr(`FTDR_DOR_IDX, 8'h04);
    chk(fdc_reset, 1'b0);
    for (int t = 0; t < 4; t++) begin
      v = $urandom;
      wr(`FTDR_TDR_IDX, {v[7:2], t[1:0]});
      chk(tape_drive, t[1:0]);
      for (int k = 0; k < 4; k++) begin
        f2 = $urandom;
        wr(`FTDR_CFGF2_IDX, f2);
        wr(`FTDR_DOR_IDX, {6'h01, k[1:0]});
        chk(tape_active, t == k && t != 0);
        @(posedge clk);
        enhanced_mode2 <= k[0];
        boot_drive <= v[1:0];
        rd_reg(`FTDR_TDR_IDX, rd);
        chk(rd, k[0] ? {26'h0, f2[2*k +: 2], v[1:0], t[1:0]} : {30'h0, t[1:0]});
      end
    end
    for (int i = 0; i < 28; i++) begin
      v = (i < 4) ? (i[0] ? 8'h25 : 8'h14) : $urandom;
      @(posedge clk);
      swap_decode <= (i < 4) ? i[1] : v[3];
      wr(`FTDR_DOR_IDX, v | 8'h04);
      chk({drive_sel0_n, drive_sel1_n, motor_on0_n, motor_on1_n}, pins(v, swap_decode));
      chk(spinning, swap_decode ? {v[4], v[5]} : {v[5], v[4]});
    end
    chk(both_selected, 1'b0);
    for (int r = 0; r < 4; r++) begin
      v = $urandom;
      d = {3'h0, v[2:0], r[1:0]};
      wr(`FTDR_DSR_IDX, d);
      chk(rate_code, r[1:0]);
      chk(precomp_code, v[2:0]);
      rd_reg(`FTDR_SHADOW_IDX, rd);
      chk(rd, {24'h0, d});
      rd_reg(`FTDR_DSR_IDX, rd);
      chk(rd, 32'h0);
      wr(`FTDR_CCR_IDX, {6'h0, ~r[1:0]});
      chk(rate_code, {~r[1:0]});
    end
    rd_reg(12'h100, rd);
    chk(rsp, `FTDR_RESP_SLVERR);
    wr(12'h100, 8'h55);
    chk(rsp, `FTDR_RESP_SLVERR);
    // A write without lane 0 enabled must leave the tape assignment alone.
    s_axi_wstrb <= 4'h0;
    wr(`FTDR_TDR_IDX, 8'h00);
    chk(tape_drive, 2'h3);
    s_axi_wstrb <= 4'h1;
    wr(`FTDR_DSR_IDX, 8'h42);
    chk(low_power, 1'b1);
    rd_reg(`FTDR_DATA_IDX, rd);
    chk(low_power, 1'b0);
    wr(`FTDR_DSR_IDX, 8'h42);
    wr(`FTDR_DSR_IDX, 8'h85);
    chk(fdc_reset, 1'b1);
    n = 0;
    while (fdc_reset && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(n >= `FTDR_SRST_CYC, 1'b1);
    chk(fdc_reset, 1'b0);
    chk(low_power, 1'b0);
    chk({rate_code, precomp_code, tape_drive}, {2'h1, 3'h1, 2'h3});
    wr(`FTDR_DOR_IDX, 8'h30);
    chk(fdc_reset, 1'b1);
    chk({rate_code, tape_drive, motor_on0_n, motor_on1_n}, 6'h1c);
    wr(`FTDR_DOR_IDX, 8'h34);
    chk(fdc_reset, 1'b0);
    hw_reset();
    end_of_test();
  end
endmodule
